// file: pulse_pkg.sv
package pulse_pkg;

  // ---------------------------------------------------------------------
  // Clocking and reference tick
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 32'h02FA_F080;   // 50 MHz
  localparam int unsigned REF_HZ = 32'h0098_9680;   // 10 MHz reference
  localparam int unsigned TICK_DIV = CLK_HZ / REF_HZ;
  localparam logic [2:0] TICK_LAST = 3'(TICK_DIV - 1);
  localparam logic [31:0] REF_HZ_W = 32'(REF_HZ);
  localparam logic [31:0] DUTY_FULL = 32'h0000_7D00; // 32000

  // ---------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [11:0] OFS_CFG = 12'h000;
  localparam logic [11:0] OFS_COIL = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam logic [11:0] OFS_QSTAT = 12'h00C;
  localparam logic [11:0] OFS_MAP = 12'h010;
  localparam logic [11:0] MAP_BASE_RST = 12'h100;
  localparam logic [11:0] TC_END = 12'h028;
  localparam logic [11:0] QUAD_OFS = 12'h040;
  localparam logic [11:0] QUAD_END = 12'h070;
  localparam logic [3:0] QD_WORDS = 4'h7;

  // Configuration bits
  localparam int CFG_QUAD = 0;
  localparam int CFG_STEP1 = 1;
  localparam int CFG_STEP2 = 2;
  localparam int CFG_ADDON = 3;

  // Start-move coil bits
  localparam int COIL_START1 = 1;
  localparam int COIL_START2 = 2;
  localparam int COIL_ADDON1 = 30;
  localparam int COIL_ADDON2 = 31;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] duty_sf;
    logic [31:0] freq_rf;
    logic [31:0] accel;
    logic [31:0] run;
    logic [31:0] decel;
  } chan_param_t;

  typedef enum logic {ST_IDLE, ST_MOVE} step_state_t;
  typedef enum logic [1:0] {PH_ACC, PH_RUN, PH_DEC, PH_END} phase_t;

  typedef struct packed {
    step_state_t st;
    phase_t ph;
    logic [31:0] cnt;
    logic [31:0] per;
    logic [31:0] hi;
    logic [31:0] idx;
    logic [31:0] sf;
    logic [31:0] rf;
    logic [31:0] ac;
    logic [31:0] rc;
    logic [31:0] dc;
    logic start_q;
    logic ready;
    logic err;
    logic pulse;
  } chan_state_t;

  typedef struct packed {
    logic [3:0] cfg;
    logic [31:0] coil;
    logic [11:0] map_base;
    logic [9:0][31:0] tc;
    logic [6:0][31:0] qd;
    logic [31:0] prdata;
    logic slverr;
    logic [2:0] tick_cnt;
    logic tick;
  } top_state_t;

endpackage

// file: pwm_stepper_pulse_output.sv
// Functional notes
// - Two-counter output 1 words at bank 0-4
// - Two-counter output 2 words at bank 5-9
// - Status bits report both steppers ready, error
// - Start coils 1,2 or 30,31 on add-on
// - Four-counter bank: stepper, PWM 2, reserved words
// - Duty full holds high, zero holds low
// - High time is duty over 32000 of period
// - Accelerate, run, decelerate after start bit
// - Ready low during move, high after
// - Periods are whole 10 MHz reference ticks
// - Parameter window relocatable by configuration
// - Start cleared mid-move aborts, sets error
// - Bad ramp counts or start frequency error
// - Output low until frequency and duty nonzero
// - Latch parameters at start, clear fixed error
`timescale 1ns/1ps

module pulse_channel
  import pulse_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Reference tick and control
  input wire logic tick,
  input wire logic step_mode,
  input wire logic start,
  input wire chan_param_t prm,
  // Output and status
  output logic pulse,
  output logic ready,
  output logic error
);

  chan_state_t s_q;
  chan_state_t s_d;
  logic [31:0] f_cur;
  logic [31:0] per_cur;
  logic [31:0] ph_len;
  logic [63:0] ramp;
  logic [63:0] hi_full;
  logic start_rise;
  logic bad;

  function automatic phase_t after(phase_t p, logic [31:0] rc,
                                   logic [31:0] dc);
    if (p == PH_ACC && rc != 32'h0)
      return PH_RUN;
    else if (p != PH_DEC && dc != 32'h0)
      return PH_DEC;
    else
      return PH_END;
  endfunction

  // -----------------------------------------------------------------
  // Step frequency and period
  // -----------------------------------------------------------------
  always_comb
  begin
    ramp = 64'h0;
    ph_len = s_q.rc;
    f_cur = s_q.rf;
    if (!step_mode)
    begin
      f_cur = prm.freq_rf;
    end
    else if (s_q.ph == PH_ACC)
    begin
      ph_len = s_q.ac;
      ramp = 64'(s_q.rf - s_q.sf) * 64'(s_q.idx) / 64'(s_q.ac - 32'h1);
      f_cur = s_q.sf + ramp[31:0];
    end
    else if (s_q.ph == PH_DEC)
    begin
      ph_len = s_q.dc;
      ramp = 64'(s_q.rf - s_q.sf) * 64'(s_q.idx) / 64'(s_q.dc - 32'h1);
      f_cur = s_q.rf - ramp[31:0];
    end
    // Whole reference ticks per period
    per_cur = (f_cur == 32'h0) ? 32'h1 : REF_HZ_W / f_cur;
    if (per_cur == 32'h0)
    begin
      per_cur = 32'h1;
    end
    hi_full = 64'(per_cur) * 64'(prm.duty_sf) / 64'(DUTY_FULL);
  end

  // -----------------------------------------------------------------
  // Channel sequencing
  // -----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.start_q = start;
    start_rise = start && !s_q.start_q;
    bad = (prm.accel == 32'h1) || (prm.decel == 32'h1) ||
          (prm.freq_rf == 32'h0) ||
          (((prm.accel != 32'h0) || (prm.decel != 32'h0)) &&
           ((prm.duty_sf == 32'h0) || (prm.duty_sf > prm.freq_rf)));
    if (!step_mode)
    begin
      s_d.st = ST_IDLE;
      s_d.ready = 1'b1;
      if (prm.freq_rf == 32'h0 || prm.duty_sf == 32'h0)
      begin
        s_d.cnt = 32'h0;
        s_d.per = 32'h0;
        s_d.hi = 32'h0;
      end
      else if (prm.duty_sf >= DUTY_FULL)
      begin
        s_d.cnt = 32'h0;
        s_d.per = 32'h0;
        s_d.hi = 32'hFFFF_FFFF;
      end
      else if (tick)
      begin
        if (s_q.cnt + 32'h1 >= s_q.per)
        begin
          s_d.cnt = 32'h0;
          s_d.per = per_cur;
          s_d.hi = hi_full[31:0];
        end
        else
        begin
          s_d.cnt = s_q.cnt + 32'h1;
        end
      end
      s_d.pulse = s_d.cnt < s_d.hi;
    end
    else
    begin
      // Drop the pwm period so a later mode change starts a fresh one
      s_d.per = 32'h0;
      s_d.hi = 32'h0;
      case (s_q.st)
        ST_IDLE:
        begin
          s_d.pulse = 1'b0;
          s_d.cnt = 32'h0;
          // A start while busy is never seen here
          if (start_rise && s_q.ready)
          begin
            s_d.err = bad;
            if (!bad)
            begin
              s_d.sf = prm.duty_sf;
              s_d.rf = prm.freq_rf;
              s_d.ac = prm.accel;
              s_d.rc = prm.run;
              s_d.dc = prm.decel;
              s_d.idx = 32'h0;
              s_d.ph = (prm.accel != 32'h0) ? PH_ACC :
                       after(PH_ACC, prm.run, prm.decel);
              if (s_d.ph != PH_END)
              begin
                s_d.st = ST_MOVE;
                s_d.ready = 1'b0;
              end
            end
          end
        end
        ST_MOVE:
        begin
          if (!start)
          begin
            s_d.st = ST_IDLE;
            s_d.ready = 1'b1;
            s_d.err = 1'b1;
            s_d.cnt = 32'h0;
          end
          else if (tick)
          begin
            if (s_q.cnt + 32'h1 >= per_cur)
            begin
              s_d.cnt = 32'h0;
              if (s_q.idx + 32'h1 < ph_len)
              begin
                s_d.idx = s_q.idx + 32'h1;
              end
              else
              begin
                s_d.idx = 32'h0;
                s_d.ph = after(s_q.ph, s_q.rc, s_q.dc);
                if (s_d.ph == PH_END)
                begin
                  s_d.st = ST_IDLE;
                  s_d.ready = 1'b1;
                end
              end
            end
            else
            begin
              s_d.cnt = s_q.cnt + 32'h1;
            end
          end
          s_d.pulse = (s_d.st == ST_MOVE) &&
                      (s_d.cnt < ((per_cur + 32'h1) >> 1));
        end
        default:
        begin
          s_d.st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.ready <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pulse = s_q.pulse;
  assign ready = s_q.ready;
  assign error = s_q.err;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  property p_duty_off;
    @(posedge clk) disable iff (!arst_n)
    (!step_mode && prm.duty_sf == 32'h0) |=> !pulse;
  endproperty
  a_duty_off: assert property (p_duty_off)
    else $error("pwm output high with zero duty");

  property p_duty_on;
    @(posedge clk) disable iff (!arst_n)
    (!step_mode && prm.duty_sf >= DUTY_FULL && prm.freq_rf != 32'h0)
      |=> pulse;
  endproperty
  a_duty_on: assert property (p_duty_on)
    else $error("pwm output low with full duty");

  property p_freq_zero;
    @(posedge clk) disable iff (!arst_n)
    (!step_mode && prm.freq_rf == 32'h0) |=> !pulse;
  endproperty
  a_freq_zero: assert property (p_freq_zero)
    else $error("pwm output high with zero frequency");

  property p_cnt_below;
    @(posedge clk) disable iff (!arst_n)
    (!step_mode && s_q.per != 32'h0) |-> (s_q.cnt < s_q.per);
  endproperty
  a_cnt_below: assert property (p_cnt_below)
    else $error("pwm tick count beyond period");

  property p_start_ok;
    @(posedge clk) disable iff (!arst_n)
    (step_mode && s_q.st == ST_IDLE && start_rise && !bad &&
     prm.accel != 32'h0) |=> (!ready && !error);
  endproperty
  a_start_ok: assert property (p_start_ok)
    else $error("valid start did not begin a clean move");

  property p_bad_ramp;
    @(posedge clk) disable iff (!arst_n)
    (step_mode && s_q.st == ST_IDLE && start_rise &&
     (prm.accel == 32'h1 || prm.decel == 32'h1)) |=> (error && ready);
  endproperty
  a_bad_ramp: assert property (p_bad_ramp)
    else $error("ramp count of one not flagged");

  property p_abort;
    @(posedge clk) disable iff (!arst_n)
    (step_mode && s_q.st == ST_MOVE && !start)
      |=> (error && ready) ##1 !pulse;
  endproperty
  a_abort: assert property (p_abort)
    else $error("cleared start did not abort the move");

  property p_busy;
    @(posedge clk) disable iff (!arst_n)
    (s_q.st == ST_MOVE) |-> !ready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("ready high during a move");

  property p_first_step;
    @(posedge clk) disable iff (!arst_n)
    (step_mode && s_q.st == ST_MOVE && s_q.ph == PH_ACC &&
     s_q.idx == 32'h0 && s_q.sf <= REF_HZ_W) |-> (per_cur == REF_HZ_W / s_q.sf);
  endproperty
  a_first_step: assert property (p_first_step)
    else $error("first ramp step not at start frequency");

endmodule

module pwm_stepper_pulse_output
  import pulse_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // APB slave
  input wire apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pulse outputs
  output logic [1:0] pulse_out
);

  top_state_t r_q;
  top_state_t r_d;
  chan_param_t prm1;
  chan_param_t prm2;
  logic [1:0] rdy;
  logic [1:0] err;
  logic start1;
  logic start2;
  logic step1;
  logic step2;
  logic [11:0] woff;
  logic [11:0] qoff;
  logic [31:0] rdv;
  logic miss;
  logic wr;

  // -----------------------------------------------------------------
  // Reference tick and register file
  // -----------------------------------------------------------------
  always_comb
  begin
    r_d = r_q;
    if (r_q.tick_cnt == TICK_LAST)
    begin
      r_d.tick_cnt = 3'h0;
      r_d.tick = 1'b1;
    end
    else
    begin
      r_d.tick_cnt = r_q.tick_cnt + 3'h1;
      r_d.tick = 1'b0;
    end
    wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    woff = apb_req.paddr - r_q.map_base;
    qoff = woff - QUAD_OFS;
    rdv = 32'h0;
    miss = 1'b0;
    if (apb_req.paddr[1:0] != 2'h0)
    begin
      miss = 1'b1;
    end
    else if (apb_req.paddr == OFS_CFG)
    begin
      rdv = {28'h0, r_q.cfg};
      if (wr)
      begin
        r_d.cfg = apb_req.pwdata[3:0];
      end
    end
    else if (apb_req.paddr == OFS_COIL)
    begin
      rdv = r_q.coil;
      if (wr)
      begin
        r_d.coil = apb_req.pwdata;
      end
    end
    else if (apb_req.paddr == OFS_STAT)
    begin
      rdv = {28'h0, err[1], rdy[1], err[0], rdy[0]};
    end
    else if (apb_req.paddr == OFS_QSTAT)
    begin
      rdv = {30'h0, err[0], rdy[0]};
    end
    else if (apb_req.paddr == OFS_MAP)
    begin
      rdv = {20'h0, r_q.map_base};
      if (wr)
      begin
        r_d.map_base = {apb_req.pwdata[11:2], 2'h0};
      end
    end
    else if (woff < TC_END)
    begin
      rdv = r_q.tc[woff[5:2]];
      if (wr)
      begin
        r_d.tc[woff[5:2]] = apb_req.pwdata;
      end
    end
    else if (woff >= QUAD_OFS && woff < QUAD_END)
    begin
      // Reserved words read zero and drop writes
      if (qoff[5:2] < QD_WORDS)
      begin
        rdv = r_q.qd[qoff[4:2]];
        if (wr)
        begin
          r_d.qd[qoff[4:2]] = apb_req.pwdata;
        end
      end
    end
    else
    begin
      miss = 1'b1;
    end
    if (apb_req.psel && !apb_req.penable)
    begin
      r_d.prdata = rdv;
      r_d.slverr = miss;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r_q <= '0;
      r_q.map_base <= MAP_BASE_RST;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // -----------------------------------------------------------------
  // Channel routing
  // -----------------------------------------------------------------
  always_comb
  begin
    start1 = r_q.cfg[CFG_ADDON] ? r_q.coil[COIL_ADDON1] :
             r_q.coil[COIL_START1];
    start2 = r_q.cfg[CFG_ADDON] ? r_q.coil[COIL_ADDON2] :
             r_q.coil[COIL_START2];
    step1 = r_q.cfg[CFG_STEP1];
    if (r_q.cfg[CFG_QUAD])
    begin
      prm1 = {r_q.qd[0], r_q.qd[1], r_q.qd[2], r_q.qd[3], r_q.qd[4]};
      prm2 = {r_q.qd[5], r_q.qd[6], 96'h0};
      step2 = 1'b0;
    end
    else
    begin
      prm1 = {r_q.tc[0], r_q.tc[1], r_q.tc[2], r_q.tc[3], r_q.tc[4]};
      prm2 = {r_q.tc[5], r_q.tc[6], r_q.tc[7], r_q.tc[8], r_q.tc[9]};
      step2 = r_q.cfg[CFG_STEP2];
    end
  end

  pulse_channel u_ch1 (
    .clk(clk),
    .arst_n(arst_n),
    .tick(r_q.tick),
    .step_mode(step1),
    .start(start1),
    .prm(prm1),
    .pulse(pulse_out[0]),
    .ready(rdy[0]),
    .error(err[0])
  );

  pulse_channel u_ch2 (
    .clk(clk),
    .arst_n(arst_n),
    .tick(r_q.tick),
    .step_mode(step2),
    .start(start2),
    .prm(prm2),
    .pulse(pulse_out[1]),
    .ready(rdy[1]),
    .error(err[1])
  );

  assign prdata = r_q.prdata;
  assign pready = apb_req.psel && apb_req.penable;
  assign pslverr = pready && r_q.slverr;

  property p_tick;
    @(posedge clk) disable iff (!arst_n)
    r_q.tick |=> !r_q.tick [*4] ##1 r_q.tick;
  endproperty
  a_tick: assert property (p_tick)
    else $error("reference tick not every five clocks");

endmodule

// file: load_model.sv
`timescale 1ns/1ps

module load_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Pulse lines seen by the load
  input wire logic [1:0] pulse_in,
  // Measurements: rising-edge count, widths in clock cycles
  output logic [1:0][31:0] rises,
  output logic [1:0][31:0] hi_len,
  output logic [1:0][31:0] per_len
);
  logic [1:0] prev_q;
  logic [1:0][31:0] hc_q;
  logic [1:0][31:0] pc_q;

  // ---------------------------------------------------------------
  // Edge counting and width measurement
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev_q <= '0;
      hc_q <= '0;
      pc_q <= '0;
      rises <= '0;
      hi_len <= '0;
      per_len <= '0;
    end
    else
    begin
      prev_q <= pulse_in;
      for (int i = 0; i < 2; i++)
      begin
        pc_q[i] <= (pulse_in[i] && !prev_q[i]) ? 32'h1 : pc_q[i] + 32'h1;
        hc_q[i] <= pulse_in[i] ? hc_q[i] + 32'h1 : 32'h0;
        if (pulse_in[i] && !prev_q[i])
        begin
          per_len[i] <= pc_q[i];
          rises[i] <= rises[i] + 32'h1;
        end
        if (!pulse_in[i] && prev_q[i])
          hi_len[i] <= hc_q[i];
      end
    end
  end
endmodule

// file: tb.sv
`timescale 1ns/1ps

module tb
  import pulse_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n;
  apb_req_t req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] pulse_out;
  logic [1:0][31:0] rises;
  logic [1:0][31:0] hi_len;
  logic [1:0][31:0] per_len;
  logic [34:0] exq[$];
  logic [34:0] it;
  logic [31:0] last_rd;
  logic [31:0] rv [10];
  logic [31:0] r0;
  int fail_count = 0;
  int checks_done = 0;

  always #10 clk = ~clk;

  pwm_stepper_pulse_output pwm_stepper_pulse_output_inst (
    .clk(clk), .arst_n(arst_n), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulse_out(pulse_out));

  load_model load_model_inst (
    .clk(clk), .arst_n(arst_n), .pulse_in(pulse_out), .rises(rises),
    .hi_len(hi_len), .per_len(per_len));

  // ---------------------------------------------------------------
  // Compare and closing report
  // ---------------------------------------------------------------
  task automatic check(string nm, logic [32:0] seen, logic [32:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // Bus master; each transfer notes what the watcher must see
  // ---------------------------------------------------------------
  task automatic apb(logic [11:0] a, logic w, logic [31:0] d,
                     logic [1:0] c, logic [32:0] e);
    int n;
    n = 0;
    @(posedge clk);
    exq.push_back({c, e});
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fail_count++;
      end_sim();
    end
    last_rd = prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(a, 1'b1, d, 2'b00, '0);
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] e);
    apb(a, 1'b0, '0, 2'b11, {1'b0, e});
  endtask

  task automatic rde(logic [11:0] a, logic w);
    apb(a, w, '0, 2'b10, {1'b1, 32'h0});
  endtask

  task automatic poll(logic [11:0] a);
    int n;
    n = 0;
    do
    begin
      apb(a, 1'b0, '0, 2'b00, '0);
      n++;
    end
    while (last_rd[0] !== 1'b1 && n < 3000);
    if (n >= 3000)
    begin
      fail_count++;
      end_sim();
    end
  endtask

  task automatic do_reset();
    arst_n <= 1'b0;
    cyc(6);
    arst_n <= 1'b1;
  endtask

  task automatic hold(logic v);
    for (int i = 0; i < 3; i++)
    begin
      cyc(173);
      check("hold", {32'h0, pulse_out[0]}, {32'h0, v});
    end
  endtask

  // ---------------------------------------------------------------
  // Watcher: takes the oldest note at each completed transfer
  // ---------------------------------------------------------------
  always @(posedge clk)
    if (req.psel && req.penable && pready === 1'b1 && exq.size() > 0)
    begin
      it = exq.pop_front();
      if (it[34])
        check("pslverr", {32'h0, pslverr}, {32'h0, it[32]});
      if (it[33])
        check("prdata", {1'b0, prdata}, {1'b0, it[31:0]});
    end

  initial
  begin
    arst_n = 1'b0;
    req = '0;
    void'($urandom(32'h967B));
    do_reset();
    rd(OFS_STAT, 32'h5);
    rd(OFS_QSTAT, 32'h1);
    rd(OFS_MAP, 32'h100);
    wr(OFS_STAT, 32'hF);
    rd(OFS_STAT, 32'h5);
    for (int i = 0; i < 10; i++)
    begin
      rv[i] = $urandom;
      wr(MAP_BASE_RST + 12'(4 * i), rv[i]);
    end
    for (int i = 0; i < 10; i++)
      rd(MAP_BASE_RST + 12'(4 * i), rv[i]);
    wr(MAP_BASE_RST + QUAD_OFS + 12'h01C, $urandom);
    rd(MAP_BASE_RST + QUAD_OFS + 12'h01C, 32'h0);
    rde(12'h800, 1'b0);
    rde(MAP_BASE_RST + 12'h002, 1'b1);
    do_reset();
    rd(MAP_BASE_RST, 32'h0);
    // PWM on both outputs
    wr(MAP_BASE_RST, 32'h3E80);
    wr(MAP_BASE_RST + 12'h014, 32'h1F40);
    wr(MAP_BASE_RST + 12'h018, 32'hC350);
    cyc(50);
    check("idle_out", {32'h0, pulse_out[0]}, 33'h0);
    check("idle_rises", {1'b0, rises[0]}, 33'h0);
    wr(MAP_BASE_RST + 12'h004, 32'h186A0);
    cyc(1600);
    check("per1", {1'b0, per_len[0]}, 33'h1F4);
    check("hi1", {1'b0, hi_len[0]}, 33'hFA);
    check("per2", {1'b0, per_len[1]}, 33'h3E8);
    check("hi2", {1'b0, hi_len[1]}, 33'hFA);
    wr(MAP_BASE_RST, DUTY_FULL);
    hold(1'b1);
    wr(MAP_BASE_RST, 32'h0);
    hold(1'b0);
    // Stepper on output 1, bad ramp count first
    wr(OFS_CFG, 32'h2);
    wr(MAP_BASE_RST, 32'hC350);
    wr(MAP_BASE_RST + 12'h004, 32'h186A0);
    wr(MAP_BASE_RST + 12'h008, 32'h1);
    wr(MAP_BASE_RST + 12'h00C, 32'h2);
    wr(MAP_BASE_RST + 12'h010, 32'h3);
    wr(OFS_COIL, 32'h2);
    rd(OFS_STAT, 32'h7);
    wr(OFS_COIL, 32'h0);
    wr(MAP_BASE_RST + 12'h008, 32'h3);
    r0 = rises[0];
    wr(OFS_COIL, 32'h2);
    rd(OFS_STAT, 32'h4);
    poll(OFS_STAT);
    check("steps", {1'b0, rises[0] - r0}, 33'h8);
    check("last_hi", {1'b0, hi_len[0]}, 33'h1F4);
    check("last_per", {1'b0, per_len[0]}, 33'h299);
    rd(OFS_STAT, 32'h5);
    // Abort in mid-move
    wr(OFS_COIL, 32'h0);
    wr(OFS_COIL, 32'h2);
    cyc(100);
    wr(OFS_COIL, 32'h0);
    cyc(2);
    check("abort_out", {32'h0, pulse_out[0]}, 33'h0);
    rd(OFS_STAT, 32'h7);
    // Add-on variant start coils
    wr(OFS_CFG, 32'hA);
    wr(OFS_COIL, 32'h2);
    rd(OFS_STAT, 32'h7);
    wr(OFS_COIL, 32'h4000_0000);
    rd(OFS_STAT, 32'h4);
    wr(OFS_COIL, 32'h0);
    rd(OFS_STAT, 32'h7);
    // Four-counter stepper
    wr(OFS_CFG, 32'h3);
    wr(MAP_BASE_RST + QUAD_OFS, 32'h186A0);
    wr(MAP_BASE_RST + QUAD_OFS + 12'h004, 32'h186A0);
    wr(MAP_BASE_RST + QUAD_OFS + 12'h00C, 32'h2);
    r0 = rises[0];
    wr(OFS_COIL, 32'h2);
    rd(OFS_QSTAT, 32'h0);
    poll(OFS_QSTAT);
    check("quad_steps", {1'b0, rises[0] - r0}, 33'h2);
    // Stepper on output 2: bad ramp on the add-on coil, then a run
    wr(OFS_COIL, 32'h0);
    wr(OFS_CFG, 32'hC);
    wr(MAP_BASE_RST + 12'h024, 32'h1);
    wr(OFS_COIL, 32'h8000_0000);
    rd(OFS_STAT, 32'hD);
    wr(OFS_COIL, 32'h0);
    wr(MAP_BASE_RST + 12'h024, 32'h0);
    wr(MAP_BASE_RST + 12'h020, 32'h2);
    wr(OFS_CFG, 32'h4);
    r0 = rises[1];
    wr(OFS_COIL, 32'h4);
    rd(OFS_STAT, 32'h1);
    cyc(2100);
    rd(OFS_STAT, 32'h5);
    check("step2_count", {1'b0, rises[1] - r0}, 33'h2);
    check("step2_hi", {1'b0, hi_len[1]}, 33'h1F4);
    // Relocated parameter window
    wr(OFS_COIL, 32'h0);
    wr(OFS_MAP, 32'h203);
    rd(OFS_MAP, 32'h200);
    wr(12'h204, rv[0]);
    rd(12'h204, rv[0]);
    rde(MAP_BASE_RST + 12'h004, 1'b0);
    end_sim();
  end
endmodule
